// >>> design/fprs_pkg.sv
package fprs_pkg;
  // Register port offsets
  localparam logic [3:0] FPRS_OFF_STATUS = 4'h0;
  localparam logic [3:0] FPRS_OFF_TAG = 4'h1;
  localparam logic [3:0] FPRS_OFF_MASK = 4'h2;
  localparam logic [3:0] FPRS_OFF_DATA_LO = 4'h3;
  localparam logic [3:0] FPRS_OFF_DATA_MID = 4'h4;
  localparam logic [3:0] FPRS_OFF_DATA_HI = 4'h5;
  localparam logic [3:0] FPRS_OFF_SEL = 4'h6;
  // Status word field positions
  localparam int FPRS_POS_BUSY = 15;
  localparam int FPRS_POS_C3 = 14;
  localparam int FPRS_POS_TOP_HI = 13;
  localparam int FPRS_POS_TOP_LO = 11;
  localparam int FPRS_POS_C2 = 10;
  localparam int FPRS_POS_C1 = 9;
  localparam int FPRS_POS_C0 = 8;
  localparam int FPRS_POS_ES = 7;
  localparam int FPRS_POS_SF = 6;
  // Reset values
  localparam logic [15:0] FPRS_RST_STATUS = 16'h0000;
  localparam logic [15:0] FPRS_RST_TAG = 16'hffff;
  localparam logic [5:0] FPRS_RST_MASK = 6'h3f;
  // Tag encodings
  localparam logic [1:0] FPRS_TAG_VALID = 2'h0;
  localparam logic [1:0] FPRS_TAG_EMPTY = 2'h3;
  // Exponent biases
  localparam logic [14:0] FPRS_BIAS_SGL = 15'h007f;
  localparam logic [14:0] FPRS_BIAS_DBL = 15'h03ff;
  localparam logic [14:0] FPRS_BIAS_EXT = 15'h3fff;
  // Commands
  typedef enum logic [3:0] {
    FPRS_CMD_NOP = 4'h0,
    FPRS_CMD_PUSH = 4'h1,
    FPRS_CMD_POP = 4'h2,
    FPRS_CMD_WRITE_ST = 4'h3,
    FPRS_CMD_ARITH = 4'h4,
    FPRS_CMD_PREM = 4'h5,
    FPRS_CMD_ENV_LOAD = 4'h6,
    FPRS_CMD_EXCEPT = 4'h7,
    FPRS_CMD_PUSH_SGL = 4'h8,
    FPRS_CMD_PUSH_DBL = 4'h9,
    FPRS_CMD_PUSH_BCD = 4'ha,
    FPRS_CMD_POP_BCD = 4'hb,
    FPRS_CMD_FREE = 4'hc
  } fprs_cmd_t;
  typedef struct packed {
    fprs_cmd_t cmd;
    logic [2:0] st_index;
    logic [79:0] value;
    logic [3:0] cond;
    logic [5:0] exc;
    logic stack_fault;
    logic [15:0] status_load;
    logic [15:0] tag_load;
  } fprs_req_t;
endpackage

// >>> design/fprs_top.sv
`timescale 1ns/1ns
// Operation
// - One sign bit, 0 positive 1 negative
// - BCD two digits/byte, filler ignored/stored zero
// - Biases 127, 1023, 16383 per format
// - Integer bit explicit extended, implicit otherwise
// - Eight 80-bit extended-format data registers
// - Push decrements top, then loads
// - Pop delivers top, then increments
// - Register operands relative to top pointer
// - Two-bit tag per register, empty marked
// - Readable 16-bit status word
// - Busy bit 15 mirrors error summary
// - Bits 13-11 hold top pointer
// - Arithmetic updates four condition bits
// - Error summary from unmasked flags drives error
// - Stack fault bit 6, cond_bit1 overflow/underflow
// - Bits 5-0 are exception flags
// - Environment load recomputes summary and busy
// - Loaded summary asserts error output immediately
// - Remainder: cond_bit2 incomplete, quotient bits
// - Incomplete reduction leaves remainder on top
module fprs_top #(
  parameter int NREG = 8
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire fprs_pkg::fprs_req_t REQ,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic [79:0] POP_VALUE,
  output logic POP_VALID,
  output logic ERROR_N
);
  import fprs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [79:0] data_reg [NREG];
  logic [15:0] tag_word;
  logic [2:0] top;
  logic [3:0] cond;
  logic sf;
  logic [5:0] exc;
  logic [5:0] mask;
  logic [2:0] sel;

  wire fprs_cmd_t cmd = REQ.cmd;
  wire is_push = cmd == FPRS_CMD_PUSH || cmd == FPRS_CMD_PUSH_SGL
    || cmd == FPRS_CMD_PUSH_DBL || cmd == FPRS_CMD_PUSH_BCD;
  wire is_pop = cmd == FPRS_CMD_POP || cmd == FPRS_CMD_POP_BCD;
  wire [2:0] top_dec = top - 3'h1;
  wire [2:0] top_inc = top + 3'h1;
  wire [2:0] st_phys = top + REQ.st_index;
  wire [5:0] next_exc = (cmd == FPRS_CMD_ENV_LOAD) ? REQ.status_load[5:0]
    : (cmd == FPRS_CMD_EXCEPT) ? (exc | REQ.exc) : exc;
  wire [5:0] next_mask = (WR && ADDR == FPRS_OFF_MASK) ? WDATA[5:0] : mask;
  wire next_es = |(next_exc & ~next_mask);
  wire es = |(exc & ~mask);
  wire [15:0] status_word = {es, cond[3], top, cond[2], cond[1], cond[0],
    es, sf, exc};

  ////////////////////////////////////////////////////////////////////////////
  // Format conversion into the extended layout
  wire sgn_s = REQ.value[31];
  wire [7:0] exp_s = REQ.value[30:23];
  wire [14:0] ext_exp_s = (exp_s == 8'h00) ? 15'h0000 :
    15'(exp_s) - FPRS_BIAS_SGL + FPRS_BIAS_EXT;
  wire [79:0] from_sgl = {sgn_s, ext_exp_s, exp_s != 8'h00,
    REQ.value[22:0], 40'h0};
  wire sgn_d = REQ.value[63];
  wire [10:0] exp_d = REQ.value[62:52];
  wire [14:0] ext_exp_d = (exp_d == 11'h000) ? 15'h0000 :
    15'(exp_d) - FPRS_BIAS_DBL + FPRS_BIAS_EXT;
  wire [79:0] from_dbl = {sgn_d, ext_exp_d, exp_d != 11'h000,
    REQ.value[51:0], 11'h0};
  // BCD kept as digits; filler bits 78:72 dropped on load
  wire [79:0] from_bcd = {REQ.value[79], 7'h00, REQ.value[71:0]};

  logic [79:0] load_val;
  always_comb begin
    case (cmd)
      FPRS_CMD_PUSH_SGL: load_val = from_sgl;
      FPRS_CMD_PUSH_DBL: load_val = from_dbl;
      FPRS_CMD_PUSH_BCD: load_val = from_bcd;
      default: load_val = REQ.value;
    endcase
  end

  wire [79:0] top_val = data_reg[top];
  wire [79:0] next_pop_val = (cmd == FPRS_CMD_POP_BCD) ?
    {top_val[79], 7'h00, top_val[71:0]} : top_val;

  ////////////////////////////////////////////////////////////////////////////
  // Data registers and tag word
  wire [2:0] wr_idx = is_push ? top_dec : st_phys;
  wire wr_en = is_push || cmd == FPRS_CMD_WRITE_ST || cmd == FPRS_CMD_PREM;

  genvar g;
  for (g = 0; g < NREG; g++) begin : g_reg
    always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
        data_reg[g] <= 80'h0;
      end else if (wr_en && wr_idx == 3'(g)) begin
        data_reg[g] <= load_val;
      end
    end
  end

  logic [15:0] next_tag;
  always_comb begin
    next_tag = tag_word;
    if (cmd == FPRS_CMD_ENV_LOAD) begin
      next_tag = REQ.tag_load;
    end else if (WR && ADDR == FPRS_OFF_TAG) begin
      next_tag = WDATA[15:0];
    end
    if (is_push || cmd == FPRS_CMD_WRITE_ST) begin
      next_tag[2*wr_idx +: 2] = FPRS_TAG_VALID;
    end else if (is_pop) begin
      next_tag[2*top +: 2] = FPRS_TAG_EMPTY;
    end else if (cmd == FPRS_CMD_FREE) begin
      next_tag[2*st_phys +: 2] = FPRS_TAG_EMPTY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word state
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      tag_word <= FPRS_RST_TAG;
      top <= FPRS_RST_STATUS[FPRS_POS_TOP_HI:FPRS_POS_TOP_LO];
      cond <= 4'h0;
      sf <= 1'b0;
      exc <= FPRS_RST_STATUS[5:0];
      mask <= FPRS_RST_MASK;
      sel <= 3'h0;
      ERROR_N <= 1'b1;
      POP_VALID <= 1'b0;
      POP_VALUE <= 80'h0;
    end else begin
      tag_word <= next_tag;
      mask <= next_mask;
      exc <= next_exc;
      ERROR_N <= ~next_es;
      POP_VALID <= is_pop;
      if (is_pop) begin
        POP_VALUE <= next_pop_val;
      end
      if (WR && ADDR == FPRS_OFF_SEL) begin
        sel <= WDATA[2:0];
      end
      if (is_push) begin
        top <= top_dec;
      end else if (is_pop) begin
        top <= top_inc;
      end
      case (cmd)
        FPRS_CMD_ARITH: cond <= REQ.cond;
        FPRS_CMD_PREM: cond <= REQ.cond;
        FPRS_CMD_EXCEPT: begin
          if (REQ.stack_fault) begin
            sf <= 1'b1;
            cond[1] <= REQ.cond[1];
          end
        end
        FPRS_CMD_ENV_LOAD: begin
          // Bits 15 and 7 of the image are ignored and recomputed
          top <= REQ.status_load[FPRS_POS_TOP_HI:FPRS_POS_TOP_LO];
          cond <= {REQ.status_load[FPRS_POS_C3], REQ.status_load[FPRS_POS_C2],
            REQ.status_load[FPRS_POS_C1], REQ.status_load[FPRS_POS_C0]};
          sf <= REQ.status_load[FPRS_POS_SF];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  wire [79:0] sel_val = data_reg[top + sel];
  logic [31:0] next_rdata;
  always_comb begin
    case (ADDR)
      FPRS_OFF_STATUS: next_rdata = {16'h0, status_word};
      FPRS_OFF_TAG: next_rdata = {16'h0, tag_word};
      FPRS_OFF_MASK: next_rdata = {26'h0, mask};
      FPRS_OFF_DATA_LO: next_rdata = sel_val[31:0];
      FPRS_OFF_DATA_MID: next_rdata = sel_val[63:32];
      FPRS_OFF_DATA_HI: next_rdata = {16'h0, sel_val[79:64]};
      FPRS_OFF_SEL: next_rdata = {29'h0, sel};
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 32'h0;
    end else begin
      RDATA <= RD ? next_rdata : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_PUSH_TOP: assert property (@(posedge MCLK) disable iff (RESET)
    is_push |=> top == $past(top) - 3'h1) else $error("push top wrong");
  AST_POP_TOP: assert property (@(posedge MCLK) disable iff (RESET)
    is_pop |=> top == $past(top) + 3'h1) else $error("pop top wrong");
  AST_PUSH_DATA: assert property (@(posedge MCLK) disable iff (RESET)
    cmd == FPRS_CMD_PUSH |=> data_reg[top] == $past(REQ.value))
    else $error("push data wrong");
  AST_POP_VAL: assert property (@(posedge MCLK) disable iff (RESET)
    cmd == FPRS_CMD_POP |=> POP_VALID && POP_VALUE == $past(top_val))
    else $error("pop value wrong");
  // Checked on the bus, so a wrong bit order in the read mux shows up
  AST_BUSY_MIRROR: assert property (@(posedge MCLK) disable iff (RESET)
    RD && ADDR == FPRS_OFF_STATUS |=> RDATA[15] == |($past(exc) & ~$past(mask)))
    else $error("busy mirror wrong");
  AST_ERROR_OUT: assert property (@(posedge MCLK) disable iff (RESET)
    ##1 ERROR_N == ~(|(exc & ~mask))) else $error("error output wrong");
  AST_ENV_ERR: assert property (@(posedge MCLK) disable iff (RESET)
    cmd == FPRS_CMD_ENV_LOAD && |(REQ.status_load[5:0] & ~next_mask) |=> !ERROR_N)
    else $error("env load error late");
  AST_TAG_PUSH: assert property (@(posedge MCLK) disable iff (RESET)
    is_push |=> tag_word[2*top +: 2] == FPRS_TAG_VALID)
    else $error("push tag wrong");
  AST_TOP_FIELD: assert property (@(posedge MCLK) disable iff (RESET)
    RD && ADDR == FPRS_OFF_STATUS |=> RDATA[13:11] == $past(top))
    else $error("top field wrong");
  AST_ARITH_COND: assert property (@(posedge MCLK) disable iff (RESET)
    cmd == FPRS_CMD_ARITH |=> cond == $past(REQ.cond))
    else $error("arith cond wrong");
  AST_EXC_STICKY: assert property (@(posedge MCLK) disable iff (RESET)
    cmd == FPRS_CMD_EXCEPT |=> exc == ($past(exc) | $past(REQ.exc)))
    else $error("exception flags wrong");
  AST_SF_COND: assert property (@(posedge MCLK) disable iff (RESET)
    cmd == FPRS_CMD_EXCEPT && REQ.stack_fault |=> sf && cond[1] == $past(REQ.cond[1]))
    else $error("stack fault wrong");
  AST_ENV_TOP: assert property (@(posedge MCLK) disable iff (RESET)
    cmd == FPRS_CMD_ENV_LOAD |=> top == $past(REQ.status_load[13:11]))
    else $error("env load top wrong");
  AST_PREM_DATA: assert property (@(posedge MCLK) disable iff (RESET)
    cmd == FPRS_CMD_PREM |=> data_reg[$past(st_phys)] == $past(REQ.value))
    else $error("remainder not kept");
  AST_POP_TAG: assert property (@(posedge MCLK) disable iff (RESET)
    is_pop |=> tag_word[2*$past(top) +: 2] == FPRS_TAG_EMPTY)
    else $error("pop tag wrong");
  AST_WRAP: assert property (@(posedge MCLK) disable iff (RESET)
    is_push && top == 3'h0 |=> top == 3'h7) else $error("top wrap wrong");
  AST_INT_BIT: assert property (@(posedge MCLK) disable iff (RESET)
    cmd == FPRS_CMD_PUSH_SGL && exp_s != 8'h00 |=> data_reg[top][63])
    else $error("integer bit missing");
  AST_BCD_FILL: assert property (@(posedge MCLK) disable iff (RESET)
    cmd == FPRS_CMD_PUSH_BCD |=> data_reg[top][78:72] == 7'h00)
    else $error("filler bits kept");
  AST_RDATA_IDLE: assert property (@(posedge MCLK) disable iff (RESET)
    !RD |=> RDATA == 32'h0) else $error("read data outside read");
endmodule

// >>> tb/fprs_host_model.sv
`timescale 1ns/1ns
module fprs_host_model (
  input wire logic MCLK,
  output fprs_pkg::fprs_req_t REQ
);
  import fprs_pkg::*;
  // Offset from top for explicit register commands
  logic [2:0] idx = 3'h0;
  initial begin
    REQ = '0;
  end
  // One command per edge; the next edge returns the port to idle
  task automatic send(input fprs_cmd_t c, input logic [79:0] v, input logic [3:0] cnd,
                      input logic [5:0] e, input logic sf, input logic [15:0] sl);
    @(posedge MCLK);
    REQ <= '{cmd: c, st_index: idx, value: v, cond: cnd, exc: e, stack_fault: sf,
             status_load: sl, tag_load: 16'hffff};
    @(posedge MCLK);
    REQ.cmd <= FPRS_CMD_NOP;
    #1;
  endtask
endmodule

// >>> tb/fprs_top_tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module fprs_top_tb_top;
  import fprs_pkg::*;
  logic MCLK = 1'b0;
  logic RESET = 1'b1;
  logic [3:0] ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic [79:0] POP_VALUE;
  logic POP_VALID;
  logic ERROR_N;
  fprs_req_t REQ;
  int err_total = 0;
  int n_tests = 0;
  localparam logic [79:0] VA = 80'h4001_c000_0000_0000_0000;
  localparam logic [79:0] VB = 80'hbfff_8000_0000_1234_5678;
  fprs_host_model i_fprs_host_model (.MCLK(MCLK), .REQ(REQ));
  fprs_top i_fprs_top (.MCLK(MCLK), .RESET(RESET), .REQ(REQ), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .POP_VALUE(POP_VALUE), .POP_VALID(POP_VALID),
    .ERROR_N(ERROR_N));
  initial begin
    forever #50 MCLK = ~MCLK;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask
  task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic t_reset;
    logic [31:0] d;
    rd(FPRS_OFF_STATUS, d);
    `CHK("status", 32'h0, d)
    rd(FPRS_OFF_TAG, d);
    `CHK("tag", 32'hffff, d)
    rd(FPRS_OFF_MASK, d);
    `CHK("mask", 32'h3f, d)
    rd(4'hf, d);
    `CHK("unmapped", 32'h0, d)
    `CHK("error_n", 1'b1, ERROR_N)
    $display("test reset done");
  endtask
  task automatic t_stack;
    logic [31:0] d;
    i_fprs_host_model.send(FPRS_CMD_PUSH, VA, 4'h0, 6'h0, 1'b0, 16'h0);
    i_fprs_host_model.send(FPRS_CMD_PUSH, VB, 4'h0, 6'h0, 1'b0, 16'h0);
    rd(FPRS_OFF_STATUS, d);
    `CHK("top after pushes", 32'h3000, d)
    rd(FPRS_OFF_TAG, d);
    `CHK("tag physical", 32'h0fff, d)
    wr(FPRS_OFF_SEL, 32'h1);
    rd(FPRS_OFF_DATA_HI, d);
    `CHK("st1 hi", {16'h0, VA[79:64]}, d)
    wr(FPRS_OFF_SEL, 32'h0);
    rd(FPRS_OFF_DATA_LO, d);
    `CHK("st0 lo", VB[31:0], d)
    i_fprs_host_model.send(FPRS_CMD_POP, 80'h0, 4'h0, 6'h0, 1'b0, 16'h0);
    `CHK("pop valid", 1'b1, POP_VALID)
    `CHK("pop value", VB, POP_VALUE)
    rd(FPRS_OFF_STATUS, d);
    `CHK("top after pop", 32'h3800, d)
    i_fprs_host_model.send(FPRS_CMD_PUSH, {80{1'b1}}, 4'h0, 6'h0, 1'b0, 16'h0);
    i_fprs_host_model.send(FPRS_CMD_POP_BCD, 80'h0, 4'h0, 6'h0, 1'b0, 16'h0);
    `CHK("bcd filler", {8'h80, {72{1'b1}}}, POP_VALUE)
    $display("test stack done");
  endtask
  task automatic t_status;
    logic [31:0] d;
    i_fprs_host_model.send(FPRS_CMD_EXCEPT, 80'h0, 4'h2, 6'h01, 1'b1, 16'h0);
    rd(FPRS_OFF_STATUS, d);
    `CHK("masked fault", 32'h3a41, d)
    `CHK("error_n masked", 1'b1, ERROR_N)
    wr(FPRS_OFF_MASK, 32'h3e);
    rd(FPRS_OFF_STATUS, d);
    `CHK("unmasked", 32'hbac1, d)
    `CHK("error_n set", 1'b0, ERROR_N)
    i_fprs_host_model.send(FPRS_CMD_ENV_LOAD, 80'h0, 4'h0, 6'h0, 1'b0, 16'h8082);
    rd(FPRS_OFF_STATUS, d);
    `CHK("env load masked", 32'h0002, d)
    `CHK("error_n clear", 1'b1, ERROR_N)
    i_fprs_host_model.send(FPRS_CMD_PREM, 80'h0, 4'hb, 6'h0, 1'b0, 16'h0);
    rd(FPRS_OFF_STATUS, d);
    `CHK("remainder codes", 32'h4302, d)
    i_fprs_host_model.send(FPRS_CMD_ENV_LOAD, 80'h0, 4'h0, 6'h0, 1'b0, 16'h0001);
    `CHK("error_n at load", 1'b0, ERROR_N)
    rd(FPRS_OFF_STATUS, d);
    `CHK("env load summary", 32'h8081, d)
    $display("test status done");
  endtask
  task automatic t_convert;
    logic [31:0] d;
    i_fprs_host_model.send(FPRS_CMD_PUSH_SGL, 80'h3fc0_0000, 4'h0, 6'h0, 1'b0, 16'h0);
    rd(FPRS_OFF_DATA_HI, d);
    `CHK("single exp", 32'h3fff, d)
    rd(FPRS_OFF_DATA_MID, d);
    `CHK("single int bit", 32'hc000_0000, d)
    i_fprs_host_model.send(FPRS_CMD_PUSH_DBL, 80'hc008_0000_0000_0000, 4'h0, 6'h0, 1'b0,
      16'h0);
    rd(FPRS_OFF_DATA_HI, d);
    `CHK("double sign exp", 32'hc000, d)
    i_fprs_host_model.idx = 3'h1;
    i_fprs_host_model.send(FPRS_CMD_WRITE_ST, VA, 4'h0, 6'h0, 1'b0, 16'h0);
    i_fprs_host_model.send(FPRS_CMD_FREE, 80'h0, 4'h0, 6'h0, 1'b0, 16'h0);
    i_fprs_host_model.idx = 3'h0;
    wr(FPRS_OFF_SEL, 32'h1);
    rd(FPRS_OFF_DATA_HI, d);
    `CHK("explicit st1", {16'h0, VA[79:64]}, d)
    wr(FPRS_OFF_SEL, 32'h0);
    rd(FPRS_OFF_TAG, d);
    `CHK("tag freed", 32'hcfff, d)
    i_fprs_host_model.send(FPRS_CMD_ARITH, 80'h0, 4'h5, 6'h0, 1'b0, 16'h0);
    rd(FPRS_OFF_STATUS, d);
    `CHK("arith codes", 32'hb581, d)
    i_fprs_host_model.send(FPRS_CMD_EXCEPT, 80'h0, 4'h0, 6'h04, 1'b0, 16'h0);
    rd(FPRS_OFF_STATUS, d);
    `CHK("sticky flags", 32'hb585, d)
    i_fprs_host_model.send(FPRS_CMD_PREM, VB, 4'h4, 6'h0, 1'b0, 16'h0);
    rd(FPRS_OFF_STATUS, d);
    `CHK("incomplete codes", 32'hb485, d)
    rd(FPRS_OFF_DATA_LO, d);
    `CHK("remainder on top", VB[31:0], d)
    i_fprs_host_model.send(FPRS_CMD_PUSH_BCD, 80'hff12_3456_7890_1234_5678, 4'h0, 6'h0,
      1'b0, 16'h0);
    rd(FPRS_OFF_DATA_HI, d);
    `CHK("bcd load filler", 32'h8012, d)
    $display("test convert done");
  endtask
  // Watchdog cuts a hang short
  initial begin
    #5000000;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge MCLK);
    RESET <= 1'b0;
    t_reset();
    t_stack();
    t_status();
    t_convert();
    stop_test();
  end
endmodule
